// File: src/cpu_state_cfg.svh
// Constants for the processor architectural state block
`ifndef CPU_STATE_CFG_SVH
`define CPU_STATE_CFG_SVH

// Status word bit positions
`define FLAG_CARRY_BIT 4'h0
`define FLAG_PARITY_BIT 4'h2
`define FLAG_NIBBLE_BIT 4'h4
`define FLAG_ZERO_BIT 4'h6
`define FLAG_SIGN_BIT 4'h7
`define FLAG_STEP_BIT 4'h8
`define FLAG_IENABLE_BIT 4'h9
`define FLAG_DIRECTION_BIT 4'hA
`define FLAG_OVERFLOW_BIT 4'hB
// Implemented bits of the status word; others read zero
`define FLAGS_IMPL_MASK 16'h0FD5
`define FLAGS_RESET 16'h0000

// Register port map (word indices)
`define ADDR_GEN0 5'h00
`define ADDR_SEG0 5'h08
`define ADDR_IP 5'h0C
`define ADDR_FLAGS 5'h0D
`define ADDR_PHYS_LO 5'h0E
`define ADDR_PHYS_HI 5'h0F

// Reset values
`define IP_RESET 16'h0000
`define SEG_RESET 16'h0000
`define CODE_SEG_RESET 16'hFFFF

`endif

// File: src/cpu_state_pkg.sv
// Types shared by the processor architectural state block
`default_nettype none
package cpu_state_pkg;
  typedef enum logic [3:0] {
    ALU_ADD = 4'h1,
    ALU_SUB = 4'h2,
    ALU_AND = 4'h3,
    ALU_OR = 4'h4,
    ALU_XOR = 4'h5,
    ALU_PASS = 4'h6,
    ALU_NOP = 4'h0
  } alu_op_e;

  typedef enum logic [1:0] {
    SEG_EXTRA = 2'h0,
    SEG_CODE = 2'h1,
    SEG_STACK = 2'h2,
    SEG_DATA = 2'h3
  } seg_sel_e;

  // Operand addressing modes (base/index combinations)
  typedef enum logic [2:0] {
    AM_BX_SI = 3'h0,
    AM_BX_DI = 3'h1,
    AM_BP_SI = 3'h2,
    AM_BP_DI = 3'h3,
    AM_SI = 3'h4,
    AM_DI = 3'h5,
    AM_BP = 3'h6,
    AM_BX = 3'h7
  } addr_mode_e;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_STEP = 3'b010,
    ST_INTR = 3'b100
  } seq_state_e;
endpackage : cpu_state_pkg
`default_nettype wire

// File: src/phys_addr_gen.sv
// Segment plus offset to 20-bit physical address
`timescale 1ns/1ps
`default_nettype none
module phys_addr_gen #(
  parameter int SEG_W = 16,
  parameter int PHYS_W = 20
) (
  // Inputs
  input wire logic [SEG_W-1:0] segment_base,
  input wire logic [SEG_W-1:0] offset,
  // Result
  output logic [PHYS_W-1:0] phys_addr
);
  if (PHYS_W != SEG_W + 4) begin : width_check_g
    $error("phys_addr_gen: PHYS_W must be SEG_W + 4");
  end

  // Carry out of the top bit is dropped so addresses wrap in 1 MByte
  assign phys_addr = PHYS_W'({segment_base, 4'h0} + {4'h0, offset});
endmodule : phys_addr_gen
`default_nettype wire

// File: src/cpu_arch_state.sv
// Architectural registers, status flags and segmented address generation
`timescale 1ns/1ps
`default_nettype none
`include "cpu_state_cfg.svh"

module cpu_arch_state #(
  parameter int DATA_W = 16,
  parameter int PHYS_W = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Execution: ALU
  input wire logic exec_valid,
  input wire cpu_state_pkg::alu_op_e exec_op,
  input wire logic exec_byte,
  input wire logic exec_use_carry,
  input wire logic [2:0] exec_dst,
  input wire logic [2:0] exec_src,
  input wire logic exec_src_imm,
  input wire logic [15:0] exec_imm,
  // Execution: sequencing
  input wire logic instr_done,
  input wire logic [15:0] instr_length,
  input wire logic maskable_irq,
  // Execution: string step
  input wire logic string_step,
  input wire logic string_dst_index,
  input wire logic string_word,
  // Execution: memory operand
  input wire logic mem_req,
  input wire cpu_state_pkg::addr_mode_e mem_mode,
  input wire logic [15:0] mem_disp,
  input wire logic seg_override,
  input wire cpu_state_pkg::seg_sel_e seg_override_sel,
  input wire logic fetch_req,
  // Bus interface side
  output logic [PHYS_W-1:0] bus_addr,
  output logic bus_addr_valid,
  // Interrupt entry
  output logic step_trap,
  output logic irq_taken,
  // Flag view
  output logic [15:0] processor_flags_word
);
  import cpu_state_pkg::*;
  if (DATA_W != 16 || PHYS_W != 20) begin : width_check_g
    $error("cpu_arch_state: only 16-bit data and 20-bit address supported");
  end
  // Index 0..7: accumulator, count, data, base, stack ptr, base ptr, src idx, dst idx
  logic [15:0] gen_reg [0:7];
  logic [15:0] seg_reg [0:3];
  logic [15:0] ip_reg;
  logic [15:0] flags_reg;
  logic [15:0] flags_next;
  logic [15:0] rdata_reg;
  logic [PHYS_W-1:0] bus_addr_reg;
  logic bus_valid_reg;
  logic step_trap_reg;
  logic irq_taken_reg;
  seq_state_e state_reg;
  seq_state_e state_next;

  // Byte register view: 0..3 low halves, 4..7 high halves of regs 0..3
  function automatic logic [7:0] read_byte(input logic [2:0] sel,
                                           input logic [15:0] r0, input logic [15:0] r1,
                                           input logic [15:0] r2, input logic [15:0] r3);
    logic [15:0] w;
    w = 16'h0000;
    case (sel[1:0])
      2'h0: w = r0;
      2'h1: w = r1;
      2'h2: w = r2;
      default: w = r3;
    endcase
    read_byte = sel[2] ? w[15:8] : w[7:0];
  endfunction : read_byte

  function automatic logic even_parity(input logic [7:0] v);
    even_parity = ~(^v);
  endfunction : even_parity

  // ALU operands and result
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [16:0] sum;
  logic [4:0] nib;
  logic [15:0] result;
  logic carry_in;
  logic is_arith;
  logic is_sub;

  always_comb begin
    op_a = exec_byte
      ? {8'h00, read_byte(exec_dst, gen_reg[0], gen_reg[1], gen_reg[2], gen_reg[3])}
      : gen_reg[exec_dst];
    if (exec_src_imm) begin
      op_b = exec_byte ? {8'h00, exec_imm[7:0]} : exec_imm;
    end else begin
      op_b = exec_byte
        ? {8'h00, read_byte(exec_src, gen_reg[0], gen_reg[1], gen_reg[2], gen_reg[3])}
        : gen_reg[exec_src];
    end
    carry_in = exec_use_carry & flags_reg[`FLAG_CARRY_BIT];
    is_sub = (exec_op == ALU_SUB);
    is_arith = (exec_op == ALU_ADD) || is_sub;
    sum = 17'h00000;
    nib = 5'h00;
    case (exec_op)
      ALU_ADD: begin
        sum = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, carry_in};
        nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in};
        result = sum[15:0];
      end
      ALU_SUB: begin
        sum = {1'b0, op_a} - {1'b0, op_b} - {16'h0000, carry_in};
        nib = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, carry_in};
        result = sum[15:0];
      end
      ALU_AND: result = op_a & op_b;
      ALU_OR: result = op_a | op_b;
      ALU_XOR: result = op_a ^ op_b;
      ALU_PASS: result = op_b;
      default: result = op_a;
    endcase
    if (exec_byte) begin
      result = {8'h00, result[7:0]};
    end
  end
  // Flag update from a result; logical ops clear carry and overflow
  logic res_top;
  logic carry_out;
  logic ovf;

  always_comb begin
    res_top = exec_byte ? result[7] : result[15];
    if (exec_byte) begin
      carry_out = sum[8] ^ (op_a[8] ^ op_b[8]);
      ovf = is_sub ? ((op_a[7] ^ op_b[7]) & (op_a[7] ^ result[7]))
                   : (~(op_a[7] ^ op_b[7]) & (op_a[7] ^ result[7]));
    end else begin
      carry_out = sum[16];
      ovf = is_sub ? ((op_a[15] ^ op_b[15]) & (op_a[15] ^ result[15]))
                   : (~(op_a[15] ^ op_b[15]) & (op_a[15] ^ result[15]));
    end
    flags_next = flags_reg;
    if (exec_valid && exec_op != ALU_NOP && exec_op != ALU_PASS) begin
      flags_next[`FLAG_CARRY_BIT] = is_arith & carry_out;
      flags_next[`FLAG_PARITY_BIT] = even_parity(result[7:0]);
      flags_next[`FLAG_NIBBLE_BIT] = is_arith & nib[4];
      flags_next[`FLAG_ZERO_BIT] = (result == 16'h0000);
      flags_next[`FLAG_SIGN_BIT] = res_top;
      flags_next[`FLAG_OVERFLOW_BIT] = is_arith & ovf;
    end
    if (state_reg == ST_STEP) begin
      flags_next[`FLAG_STEP_BIT] = 1'b0;
    end
    if (state_reg == ST_INTR) begin
      flags_next[`FLAG_IENABLE_BIT] = 1'b0;
      flags_next[`FLAG_STEP_BIT] = 1'b0;
    end
    if (reg_write && reg_addr == `ADDR_FLAGS) begin
      flags_next = reg_wdata & `FLAGS_IMPL_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flags_reg <= `FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // General registers: ALU write-back, string index step, software write
  logic [15:0] str_delta;
  logic [2:0] str_idx;
  assign str_delta = string_word ? 16'h0002 : 16'h0001;
  assign str_idx = string_dst_index ? 3'h7 : 3'h6;

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) begin
        gen_reg[i] <= 16'h0000;
      end
    end else begin
      if (exec_valid && exec_op != ALU_NOP) begin
        if (exec_byte) begin
          if (exec_dst[2]) begin
            gen_reg[exec_dst[1:0]][15:8] <= result[7:0];
          end else begin
            gen_reg[exec_dst[1:0]][7:0] <= result[7:0];
          end
        end else begin
          gen_reg[exec_dst] <= result;
        end
      end
      if (string_step) begin
        if (flags_reg[`FLAG_DIRECTION_BIT]) begin
          gen_reg[str_idx] <= gen_reg[str_idx] - str_delta;
        end else begin
          gen_reg[str_idx] <= gen_reg[str_idx] + str_delta;
        end
      end
      if (reg_write && reg_addr[4:3] == 2'b00) begin
        gen_reg[reg_addr[2:0]] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        seg_reg[i] <= (i == 1) ? `CODE_SEG_RESET : `SEG_RESET;
      end
    end else if (reg_write && reg_addr[4:2] == 3'b010) begin
      seg_reg[reg_addr[1:0]] <= reg_wdata;
    end
  end
  // Instruction pointer advances past each completed instruction
  always_ff @(posedge clock) begin
    if (reset) begin
      ip_reg <= `IP_RESET;
    end else if (reg_write && reg_addr == `ADDR_IP) begin
      ip_reg <= reg_wdata;
    end else if (instr_done) begin
      ip_reg <= ip_reg + instr_length;
    end
  end
  // Interrupt sequencing; single step takes priority over maskable
  always_comb begin
    state_next = ST_RUN;
    case (state_reg)
      ST_RUN: begin
        if (instr_done && flags_reg[`FLAG_STEP_BIT]) begin
          state_next = ST_STEP;
        end else if (instr_done && maskable_irq && flags_reg[`FLAG_IENABLE_BIT]) begin
          state_next = ST_INTR;
        end
      end
      ST_STEP: state_next = ST_RUN;
      ST_INTR: state_next = ST_RUN;
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= ST_RUN;
      step_trap_reg <= 1'b0;
      irq_taken_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      step_trap_reg <= (state_next == ST_STEP);
      irq_taken_reg <= (state_next == ST_INTR);
    end
  end

  // Effective offset from base and index registers
  logic [15:0] eff_offset;
  seg_sel_e seg_sel;
  logic [15:0] seg_base;
  logic [15:0] addr_offset;
  logic [PHYS_W-1:0] phys;

  always_comb begin
    case (mem_mode)
      AM_BX_SI: eff_offset = gen_reg[3] + gen_reg[6];
      AM_BX_DI: eff_offset = gen_reg[3] + gen_reg[7];
      AM_BP_SI: eff_offset = gen_reg[5] + gen_reg[6];
      AM_BP_DI: eff_offset = gen_reg[5] + gen_reg[7];
      AM_SI: eff_offset = gen_reg[6];
      AM_DI: eff_offset = gen_reg[7];
      AM_BP: eff_offset = gen_reg[5];
      default: eff_offset = gen_reg[3];
    endcase
    // Offset stays 16 bits, so a segment never exceeds 64K bytes
    eff_offset = eff_offset + mem_disp;
    if (fetch_req) begin
      seg_sel = SEG_CODE;
      addr_offset = ip_reg;
    end else begin
      addr_offset = eff_offset;
      if (seg_override) begin
        seg_sel = seg_override_sel;
      end else if (mem_mode == AM_BP_SI || mem_mode == AM_BP_DI || mem_mode == AM_BP) begin
        seg_sel = SEG_STACK;
      end else begin
        seg_sel = SEG_DATA;
      end
    end
    seg_base = seg_reg[seg_sel];
  end

  phys_addr_gen #(.SEG_W(16), .PHYS_W(PHYS_W)) u_addr (.segment_base(seg_base),
    .offset(addr_offset), .phys_addr(phys));

  always_ff @(posedge clock) begin
    if (reset) begin
      bus_addr_reg <= '0;
      bus_valid_reg <= 1'b0;
    end else begin
      bus_valid_reg <= mem_req | fetch_req;
      if (mem_req || fetch_req) begin
        bus_addr_reg <= phys;
      end
    end
  end
  // Read port; unmapped addresses return zero
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (reg_read) begin
      if (reg_addr[4:3] == 2'b00) begin
        rdata_reg <= gen_reg[reg_addr[2:0]];
      end else if (reg_addr[4:2] == 3'b010) begin
        rdata_reg <= seg_reg[reg_addr[1:0]];
      end else if (reg_addr == `ADDR_IP) begin
        rdata_reg <= ip_reg;
      end else if (reg_addr == `ADDR_FLAGS) begin
        rdata_reg <= flags_reg;
      end else if (reg_addr == `ADDR_PHYS_LO) begin
        rdata_reg <= bus_addr_reg[15:0];
      end else if (reg_addr == `ADDR_PHYS_HI) begin
        rdata_reg <= {12'h000, bus_addr_reg[19:16]};
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign bus_addr = bus_addr_reg;
  assign bus_addr_valid = bus_valid_reg;
  assign step_trap = step_trap_reg;
  assign irq_taken = irq_taken_reg;
  assign processor_flags_word = flags_reg;
endmodule : cpu_arch_state
`default_nettype wire

// File: bench/cpu_arch_state_sva.sv
// Port-level checks for the architectural state block
`timescale 1ns/1ps
`default_nettype none
`include "cpu_state_cfg.svh"
module cpu_arch_state_sva
  import cpu_state_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Requests
  input wire logic reg_write,
  input wire logic exec_valid,
  input wire cpu_state_pkg::alu_op_e exec_op,
  input wire logic instr_done,
  input wire logic maskable_irq,
  input wire logic mem_req,
  input wire logic fetch_req,
  // Results
  input wire logic bus_addr_valid,
  input wire logic step_trap,
  input wire logic irq_taken,
  input wire logic [15:0] processor_flags_word
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic step_on = processor_flags_word[8];
  wire logic ien_on = processor_flags_word[9];
  sequence step_entry_s;
    instr_done && step_on && !reg_write && !step_trap && !irq_taken;
  endsequence
  sequence step_exit_s;
    step_trap ##1 !step_on;
  endsequence
  sequence irq_exit_s;
    irq_taken ##1 !ien_on;
  endsequence
  step_trap_fires_a: assert property (step_entry_s |=> step_exit_s)
    else $error("step trap not taken");
  trap_cause_a: assert property (step_trap |-> $past(instr_done && step_on))
    else $error("step trap without cause");
  irq_entry_a: assert property (instr_done && !step_on && maskable_irq && ien_on
    && !reg_write && !step_trap && !irq_taken |=> irq_exit_s) else $error("interrupt not taken");
  irq_masked_a: assert property (irq_taken |-> $past(instr_done && maskable_irq && ien_on))
    else $error("interrupt taken while masked");
  addr_valid_a: assert property ((mem_req || fetch_req) |=> bus_addr_valid)
    else $error("address valid missing");
  addr_cause_a: assert property (bus_addr_valid |-> $past(mem_req || fetch_req))
    else $error("address valid without request");
  flag_mask_a: assert property ((processor_flags_word & ~`FLAGS_IMPL_MASK) == 16'h0000)
    else $error("unimplemented flag bit set");
  logic_clear_a: assert property (exec_valid && exec_op inside {ALU_AND, ALU_OR, ALU_XOR}
    && !reg_write |=> (processor_flags_word & 16'h0811) == 16'h0000)
    else $error("logical op left carry flags");
  pass_keep_a: assert property (exec_valid && exec_op inside {ALU_PASS, ALU_NOP}
    && !reg_write && !instr_done && !step_trap && !irq_taken |=> $stable(processor_flags_word))
    else $error("flags changed on pass");
endmodule : cpu_arch_state_sva

bind cpu_arch_state cpu_arch_state_sva cpu_arch_state_sva_i (.clock(clock), .reset(reset),
  .reg_write(reg_write), .exec_valid(exec_valid), .exec_op(exec_op),
  .instr_done(instr_done), .maskable_irq(maskable_irq), .mem_req(mem_req),
  .fetch_req(fetch_req), .bus_addr_valid(bus_addr_valid), .step_trap(step_trap),
  .irq_taken(irq_taken), .processor_flags_word(processor_flags_word));
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the architectural state block
`timescale 1ns/1ps
`default_nettype none
`include "cpu_state_cfg.svh"
module testbench;
  import cpu_state_pkg::*;
  typedef struct {alu_op_e op; logic b, c; logic [2:0] d; logic [15:0] imm, val, fl;} alu_case_s;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic exec_valid = 1'b0;
  alu_op_e exec_op = ALU_NOP;
  logic exec_byte = 1'b0;
  logic exec_use_carry = 1'b0;
  logic [2:0] exec_dst = 3'h0;
  logic [2:0] exec_src = 3'h0;
  logic exec_src_imm = 1'b1;
  logic [15:0] exec_imm = 16'h0000;
  logic instr_done = 1'b0;
  logic maskable_irq = 1'b0;
  logic string_step = 1'b0;
  logic string_dst_index = 1'b0;
  logic string_word = 1'b0;
  logic mem_req = 1'b0;
  addr_mode_e mem_mode = AM_BX_SI;
  logic [15:0] mem_disp = 16'h0000;
  logic seg_override = 1'b0;
  seg_sel_e seg_override_sel = SEG_EXTRA;
  logic fetch_req = 1'b0;
  logic [19:0] bus_addr;
  logic bus_addr_valid, step_trap, irq_taken;
  logic [15:0] processor_flags_word;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  // Each step leaves the accumulator for the next, so order matters
  alu_case_s t [11] = '{
    '{ALU_ADD, 1'b0, 1'b0, 3'h0, 16'h0001, 16'h0000, 16'h0055},
    '{ALU_ADD, 1'b0, 1'b1, 3'h0, 16'h7FFE, 16'h7FFF, 16'h0004},
    '{ALU_ADD, 1'b0, 1'b0, 3'h0, 16'h0001, 16'h8000, 16'h0894},
    '{ALU_SUB, 1'b0, 1'b0, 3'h0, 16'h8001, 16'hFFFF, 16'h0095},
    '{ALU_XOR, 1'b0, 1'b0, 3'h0, 16'hFFFF, 16'h0000, 16'h0044},
    '{ALU_OR, 1'b0, 1'b0, 3'h0, 16'h0034, 16'h0034, 16'h0000},
    '{ALU_ADD, 1'b1, 1'b0, 3'h4, 16'h0080, 16'h8034, 16'h0080},
    '{ALU_AND, 1'b0, 1'b0, 3'h0, 16'h00F0, 16'h0030, 16'h0004},
    '{ALU_SUB, 1'b1, 1'b0, 3'h0, 16'h0031, 16'h00FF, 16'h0095},
    '{ALU_PASS, 1'b0, 1'b0, 3'h0, 16'h1234, 16'h1234, 16'h0095},
    '{ALU_NOP, 1'b0, 1'b0, 3'h0, 16'h5555, 16'h1234, 16'h0095}};

  cpu_arch_state cpu_arch_state_i (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .exec_valid(exec_valid), .exec_op(exec_op), .exec_byte(exec_byte),
    .exec_use_carry(exec_use_carry), .exec_dst(exec_dst), .exec_src(exec_src),
    .exec_src_imm(exec_src_imm), .exec_imm(exec_imm), .instr_done(instr_done),
    .instr_length(16'h0003), .maskable_irq(maskable_irq), .string_step(string_step),
    .string_dst_index(string_dst_index), .string_word(string_word), .mem_req(mem_req),
    .mem_mode(mem_mode), .mem_disp(mem_disp), .seg_override(seg_override),
    .seg_override_sel(seg_override_sel), .fetch_req(fetch_req), .bus_addr(bus_addr),
    .bus_addr_valid(bus_addr_valid), .step_trap(step_trap), .irq_taken(irq_taken),
    .processor_flags_word(processor_flags_word));

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(what, {4'h0, reg_rdata}, {4'h0, exp});
  endtask : rd

  task automatic mem(input addr_mode_e m, input logic [15:0] disp, input logic ov,
                     input seg_sel_e sel, input logic [19:0] exp);
    @(posedge clock);
    mem_mode <= m;
    mem_disp <= disp;
    seg_override <= ov;
    seg_override_sel <= sel;
    mem_req <= ~fetch_req;
    fetch_req <= (m == AM_BX_SI) && (disp == 16'hFFFF);
    @(posedge clock);
    mem_req <= 1'b0;
    fetch_req <= 1'b0;
    #1 check("bus_addr", bus_addr, exp);
    check("addr_valid", {19'h0, bus_addr_valid}, 20'h00001);
  endtask : mem

  task automatic done_chk(input logic irq, input logic st, input logic it);
    @(posedge clock);
    instr_done <= 1'b1;
    maskable_irq <= irq;
    @(posedge clock);
    instr_done <= 1'b0;
    maskable_irq <= 1'b0;
    #1 check("step_trap", {19'h0, step_trap}, {19'h0, st});
    check("irq_taken", {19'h0, irq_taken}, {19'h0, it});
  endtask : done_chk

  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Cut a hang short well beyond the roughly 160 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    rd(`ADDR_FLAGS, `FLAGS_RESET, "flags_rst");
    rd(5'h09, `CODE_SEG_RESET, "code_seg_rst");
    rd(`ADDR_IP, `IP_RESET, "ip_rst");
    rd(5'h1F, 16'h0000, "unmapped");
    wr(`ADDR_FLAGS, 16'hFFFF);
    rd(`ADDR_FLAGS, `FLAGS_IMPL_MASK, "flags_mask");
    wr(`ADDR_FLAGS, 16'h0000);
    $display("registers test done");
    wr(`ADDR_GEN0, 16'hFFFF);
    foreach (t[i]) begin
      @(posedge clock);
      exec_op <= t[i].op;
      exec_byte <= t[i].b;
      exec_use_carry <= t[i].c;
      exec_dst <= t[i].d;
      exec_imm <= t[i].imm;
      exec_valid <= 1'b1;
      @(posedge clock);
      exec_valid <= 1'b0;
      rd(`ADDR_GEN0, t[i].val, "result");
      rd(`ADDR_FLAGS, t[i].fl, "flags");
      check("flags_port", {4'h0, processor_flags_word}, {4'h0, t[i].fl});
    end
    // Register source: high half of the accumulator added into its low half
    @(posedge clock);
    exec_op <= ALU_ADD;
    exec_byte <= 1'b1;
    exec_use_carry <= 1'b0;
    exec_dst <= 3'h0;
    exec_src <= 3'h4;
    exec_src_imm <= 1'b0;
    exec_valid <= 1'b1;
    @(posedge clock);
    exec_valid <= 1'b0;
    rd(`ADDR_GEN0, 16'h1246, "byte_src");
    rd(`ADDR_FLAGS, 16'h0000, "byte_src_flags");
    $display("alu test done");
    wr(5'h03, 16'h0010);
    wr(5'h05, 16'h0020);
    wr(5'h06, 16'h0100);
    wr(5'h07, 16'h0200);
    wr(5'h08, 16'hFFFF);
    wr(5'h0A, 16'h2000);
    wr(5'h0B, 16'h1000);
    mem(AM_BX_SI, 16'h0000, 1'b0, SEG_EXTRA, 20'h10110);
    mem(AM_BP_DI, 16'h0000, 1'b0, SEG_EXTRA, 20'h20220);
    mem(AM_BP, 16'h0000, 1'b0, SEG_EXTRA, 20'h20020);
    mem(AM_SI, 16'hFFFF, 1'b0, SEG_EXTRA, 20'h100FF);
    mem(AM_DI, 16'h0000, 1'b1, SEG_EXTRA, 20'h001F0);
    mem(AM_BX, 16'h0000, 1'b1, SEG_CODE, 20'h00000);
    // Fetch takes priority over a data request in the same cycle
    mem(AM_BX_SI, 16'hFFFF, 1'b0, SEG_EXTRA, 20'hFFFF0);
    rd(`ADDR_PHYS_LO, 16'hFFF0, "phys_lo");
    rd(`ADDR_PHYS_HI, 16'h000F, "phys_hi");
    done_chk(1'b0, 1'b0, 1'b0);
    rd(`ADDR_IP, 16'h0003, "ip_step");
    $display("address test done");
    @(posedge clock);
    string_step <= 1'b1;
    string_dst_index <= 1'b1;
    string_word <= 1'b1;
    @(posedge clock);
    string_step <= 1'b0;
    rd(5'h07, 16'h0202, "dst_index");
    wr(`ADDR_FLAGS, 16'h0400);
    @(posedge clock);
    string_step <= 1'b1;
    string_dst_index <= 1'b0;
    string_word <= 1'b0;
    @(posedge clock);
    string_step <= 1'b0;
    rd(5'h06, 16'h00FF, "src_index");
    $display("string test done");
    wr(`ADDR_FLAGS, 16'h0100);
    done_chk(1'b1, 1'b1, 1'b0);
    rd(`ADDR_FLAGS, 16'h0000, "step_clear");
    done_chk(1'b1, 1'b0, 1'b0);
    wr(`ADDR_FLAGS, 16'h0200);
    done_chk(1'b1, 1'b0, 1'b1);
    rd(`ADDR_FLAGS, 16'h0000, "ien_clear");
    $display("trap test done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
